// file: src/mt_defs.svh
`ifndef MT_DEFS_SVH
`define MT_DEFS_SVH

// Bus geometry
`define MT_ADDR_W        6
`define MT_DATA_W        32

// Register word offsets within one timer (address bits 3:2)
`define MT_SC_OFS        2'h0
`define MT_CLK_OFS       2'h1
`define MT_CNT_OFS       2'h2
`define MT_TERM_OFS      2'h3
// Timer select bit and option register
`define MT_TIMER_BIT     4
`define MT_OPT_ADDR      6'h20

// Status/control field positions
`define MT_SC_FLAG_BIT   7
`define MT_SC_IRQEN_BIT  6
`define MT_SC_RST_BIT    5
`define MT_SC_HALT_BIT   4

// Clock configuration field positions
`define MT_CLK_SRC_HI    5
`define MT_CLK_SRC_LO    4
`define MT_CLK_PRE_HI    3
`define MT_CLK_PRE_LO    0

// Option register field position
`define MT_OPT_CASC_BIT  0

// Reset values
`define MT_SC_RST        8'h10
`define MT_CLK_RST       8'h00
`define MT_CNT_RST       8'h00
`define MT_TERM_RST      8'h00
`define MT_OPT_RST       8'h00

// Prescaler limits
`define MT_PRE_MAX_SEL   4'h8
`define MT_FREE_TOP      8'hff

`endif

// file: src/mt_pkg.sv
package mt_pkg;

   typedef enum logic [1:0]
   {
      MT_SRC_BUS      = 2'b00,
      MT_SRC_FIXED    = 2'b01,
      MT_SRC_EXT_FALL = 2'b10,
      MT_SRC_EXT_RISE = 2'b11
   } mt_src_type;

   typedef struct packed
   {
      logic       irq_en;
      logic       halt;
      mt_src_type source_select;
      logic [3:0] prescale_select;
   } mt_ctrl_type;

   typedef struct packed
   {
      logic fixed;
      logic ext_rise;
      logic ext_fall;
      logic cascade;
      logic casc_evt;
   } mt_events_type;

endpackage

// file: src/mt_prescaler.sv
`timescale 1ns/100ps
`include "mt_defs.svh"

module mt_prescaler
   import mt_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire mt_ctrl_type   ctrl,
   input  wire mt_events_type events,
   input  wire logic          run,
   output wire logic          tick
);

   logic [7:0] div;
   wire        ext_evt;
   wire        src_evt;
   wire  [7:0] mask;
   wire  [8:0] mask_wide;
   wire        step;

   // Source edge selection
   assign ext_evt = events.cascade ? events.casc_evt :
                    (ctrl.source_select == MT_SRC_EXT_FALL) ? events.ext_fall :
                    events.ext_rise;
   assign src_evt = (ctrl.source_select == MT_SRC_BUS)   ? 1'b1 :
                    (ctrl.source_select == MT_SRC_FIXED) ? events.fixed :
                    ext_evt;

   // Power of two divide, large codes clamp to 256
   assign mask_wide = (9'h1 << ctrl.prescale_select) - 9'h1;
   assign mask      = (ctrl.prescale_select >= `MT_PRE_MAX_SEL) ?
                      `MT_FREE_TOP : mask_wide[7:0];

   assign step = run & src_evt;
   assign tick = step & ((div & mask) == mask);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         div <= 8'h00;
      else if (step)
         div <= div + 8'h01;
   end

endmodule

// file: src/mt_modulo_timer.sv
// Functional notes
// - 8-bit up-counter, free or modulo limited
// - Cascade: timer one counts timer two overflows when timer one has an external source
// - Four sources: bus, fixed, external rise/fall
// - Nine divide ratios, 1 to 256
// - Keeps counting in wait; irq wakes
// - Halted in stop, no stop wakeup
// - Stop exit keeps state; reset restores
// - Debug suspends counting, then resumes
// - External clock synchronised before use
// - Overflow flag set on wrap, not writable
// - Flag cleared by read then zero write
// - Counter reset or terminal write clears flag
// - Irq enable bit 6, irq while flag set
// - Write-one counter reset bit, reads zero
// - Halt bit freezes counter, set by reset
// - Status bits 3:0 read zero
// - Four 8-bit registers per timer
// - Source encoding; change keeps count
// - Prescale codes above 8 divide by 256
// - Terminal zero free-runs; write clears count
// - Count register read-only, reset zero
`timescale 1ns/100ps
`include "mt_defs.svh"

module mt_modulo_timer
   import mt_pkg::*;
#(
   parameter int NUM_TIMERS = 2
)
(
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic [`MT_ADDR_W-1:0]   address,
   input  wire logic                    read,
   input  wire logic                    write,
   input  wire logic [`MT_DATA_W-1:0]   writedata,
   input  wire logic [3:0]              byteenable,
   output logic      [`MT_DATA_W-1:0]   readdata,
   output wire logic                    waitrequest,
   input  wire logic [NUM_TIMERS-1:0]   ext_count_clock,
   input  wire logic                    fixed_freq_clock_en,
   input  wire logic                    wait_mode,
   input  wire logic                    stop_mode,
   input  wire logic                    debug_active,
   output wire logic [NUM_TIMERS-1:0]   overflow_irq
);

   // Bus handshake
   logic                    ack;
   logic                    cascade_enable;
   logic [7:0]              rd_mux_q;
   wire                     req;
   wire                     rd_acc;
   wire                     wr_acc;
   wire                     opt_sel;
   wire  [1:0]              reg_sel;
   wire                     timer_sel;
   wire  [7:0]              wbyte;
   wire  [7:0]              opt_rd;
   wire  [7:0]              rd_mux;
   wire                     run_global;

   // Per timer views
   wire  [7:0]              rd_val   [NUM_TIMERS];
   wire  [NUM_TIMERS-1:0]   ovf_pulse;

   assign req         = read | write;
   assign waitrequest = req & ~ack;
   assign rd_acc      = read & ack;
   assign wr_acc      = write & ack & byteenable[0];
   assign wbyte       = writedata[7:0];
   assign opt_sel     = (address == `MT_OPT_ADDR);
   assign timer_sel   = address[`MT_TIMER_BIT];
   assign reg_sel     = address[3:2];

   // Wait mode does not gate counting
   assign run_global  = ~stop_mode & ~debug_active;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ack <= 1'b0;
      else
         ack <= req & ~ack;
   end

   // Cascade option register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cascade_enable <= 1'b0;
      else if (wr_acc && opt_sel)
         cascade_enable <= wbyte[`MT_OPT_CASC_BIT];
   end

   assign opt_rd = {7'h00, cascade_enable};

   assign rd_mux = opt_sel ? opt_rd :
                   (address[`MT_ADDR_W-1:5] != '0) ? 8'h00 :
                   (NUM_TIMERS > 1 && timer_sel) ? rd_val[NUM_TIMERS-1] :
                   rd_val[0];

   // Read data captured during the wait cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rd_mux_q <= 8'h00;
      else if (read && !ack)
         rd_mux_q <= rd_mux;
   end

   assign readdata = {24'h000000, rd_mux_q};

   genvar i;
   generate
      for (i = 0; i < NUM_TIMERS; i = i + 1)
      begin : g_timer
         mt_ctrl_type   ctrl;
         mt_events_type events;
         logic [7:0]    count;
         logic [7:0]    terminal_value;
         logic          overflow_flag;
         logic          clear_armed;
         logic          ext_s1;
         logic          ext_s2;
         logic          ext_prev;
         logic [7:0]    next_count;
         logic          next_flag;
         wire           hit;
         wire           wr_sc;
         wire           wr_clk;
         wire           wr_term;
         wire           rd_sc;
         wire           cnt_clr;
         wire           sw_clr;
         wire           wrap;
         wire           tick;
         wire           run;
         wire  [7:0]    sc_rd;
         wire  [7:0]    clk_rd;

         assign hit     = !opt_sel && (address[`MT_ADDR_W-1:5] == '0) &&
                          (timer_sel == 1'(i));
         assign wr_sc   = wr_acc & hit & (reg_sel == `MT_SC_OFS);
         assign wr_clk  = wr_acc & hit & (reg_sel == `MT_CLK_OFS);
         assign wr_term = wr_acc & hit & (reg_sel == `MT_TERM_OFS);
         assign rd_sc   = rd_acc & hit & (reg_sel == `MT_SC_OFS);

         // External pin: two flops, then edge detect
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               ext_s1   <= 1'b0;
               ext_s2   <= 1'b0;
               ext_prev <= 1'b0;
            end
            else
            begin
               ext_s1   <= ext_count_clock[i];
               ext_s2   <= ext_s1;
               ext_prev <= ext_s2;
            end
         end

         assign events.fixed    = fixed_freq_clock_en;
         assign events.ext_rise = ext_s2 & ~ext_prev;
         assign events.ext_fall = ~ext_s2 & ext_prev;
         assign events.cascade  = (i == 0) && (NUM_TIMERS > 1) &&
                                  cascade_enable;
         assign events.casc_evt = ovf_pulse[NUM_TIMERS-1];

         assign run = run_global & ~ctrl.halt;

         mt_prescaler u_prescaler
         (
            .clk    (clk),
            .rst_n  (rst_n),
            .ctrl   (ctrl),
            .events (events),
            .run    (run),
            .tick   (tick)
         );

         // Terminal zero means full 8-bit range
         assign wrap    = (terminal_value == 8'h00) ?
                          (count == `MT_FREE_TOP) :
                          (count == terminal_value);
         assign cnt_clr = (wr_sc & wbyte[`MT_SC_RST_BIT]) | wr_term;
         assign sw_clr  = wr_sc & clear_armed & ~wbyte[`MT_SC_FLAG_BIT];
         assign ovf_pulse[i] = tick & wrap & ~cnt_clr;

         always_comb
         begin
            next_count = count;
            if (cnt_clr)
               next_count = 8'h00;
            else if (tick)
               next_count = wrap ? 8'h00 : count + 8'h01;
         end

         // Hardware set wins over the software clear; counter clear suppresses the set
         always_comb
         begin
            next_flag = overflow_flag;
            if (ovf_pulse[i])
               next_flag = 1'b1;
            else if (cnt_clr || sw_clr)
               next_flag = 1'b0;
         end

         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               count         <= `MT_CNT_RST;
               overflow_flag <= 1'b0;
            end
            else
            begin
               count         <= next_count;
               overflow_flag <= next_flag;
            end
         end

         // Read of a set flag arms the clear
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               clear_armed <= 1'b0;
            else if (rd_sc)
               clear_armed <= overflow_flag;
            else if (wr_sc || !overflow_flag)
               clear_armed <= 1'b0;
         end

         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               ctrl.irq_en <= 1'(`MT_SC_RST >> `MT_SC_IRQEN_BIT);
               ctrl.halt   <= 1'b1;
            end
            else if (wr_sc)
            begin
               ctrl.irq_en <= wbyte[`MT_SC_IRQEN_BIT];
               ctrl.halt   <= wbyte[`MT_SC_HALT_BIT];
            end
         end

         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               ctrl.source_select   <= MT_SRC_BUS;
               ctrl.prescale_select <= 4'(`MT_CLK_RST);
            end
            else if (wr_clk)
            begin
               ctrl.source_select   <= mt_src_type'(
                  wbyte[`MT_CLK_SRC_HI:`MT_CLK_SRC_LO]);
               ctrl.prescale_select <= wbyte[`MT_CLK_PRE_HI:`MT_CLK_PRE_LO];
            end
         end

         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               terminal_value <= `MT_TERM_RST;
            else if (wr_term)
               terminal_value <= wbyte;
         end

         // Register read views
         assign sc_rd  = {overflow_flag, ctrl.irq_en, 1'b0,
                          ctrl.halt, 4'h0};
         assign clk_rd = {2'b00, ctrl.source_select,
                          ctrl.prescale_select};

         assign rd_val[i] = (reg_sel == `MT_SC_OFS)  ? sc_rd :
                            (reg_sel == `MT_CLK_OFS) ? clk_rd :
                            (reg_sel == `MT_CNT_OFS) ? count :
                            terminal_value;

         // Level request, also valid in wait mode
         assign overflow_irq[i] = overflow_flag & ctrl.irq_en;
      end
   endgenerate

endmodule

// file: verification/mt_modulo_timer_asserts.sv
`timescale 1ns/100ps
`include "mt_defs.svh"

module mt_modulo_timer_asserts
#(
   parameter int NUM_TIMERS = 2
)
(
   input wire logic                  clk,
   input wire logic                  rst_n,
   input wire logic [`MT_ADDR_W-1:0] address,
   input wire logic                  read,
   input wire logic                  write,
   input wire logic [`MT_DATA_W-1:0] writedata,
   input wire logic [3:0]            byteenable,
   input wire logic [`MT_DATA_W-1:0] readdata,
   input wire logic                  waitrequest,
   input wire logic [NUM_TIMERS-1:0] ext_count_clock,
   input wire logic                  fixed_freq_clock_en,
   input wire logic                  wait_mode,
   input wire logic                  stop_mode,
   input wire logic                  debug_active,
   input wire logic [NUM_TIMERS-1:0] overflow_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire rd_ok = read && !waitrequest;
   wire wr_ok = write && !waitrequest && byteenable[0];

   one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered after one wait");
   idle_ready_a: assert property (!(read || write) |-> !waitrequest)
      else $error("wait raised without request");
   sc_zero_a: assert property (rd_ok && address == 6'h00 |->
      readdata[5:0] == 6'h10 || readdata[5:0] == 6'h00)
      else $error("status low bits not zero");
   clk_zero_a: assert property (rd_ok && address == 6'h04 |-> readdata[31:6] == 26'h0)
      else $error("clock config upper bits set");
   unmapped_read_a: assert property (rd_ok && address == 6'h3c |-> readdata == 32'h0)
      else $error("unmapped read not zero");
   term_clear_a: assert property (wr_ok && address == 6'h0c |=> !overflow_irq[0])
      else $error("terminal write left irq");
   trst_clear_a: assert property (wr_ok && address == 6'h00 && writedata[5] |=>
      !overflow_irq[0])
      else $error("counter reset left irq");
   irq_off_a: assert property (wr_ok && address == 6'h00 && !writedata[6] |=>
      !overflow_irq[0])
      else $error("irq without enable");
   irq_frozen_a: assert property ((stop_mode || debug_active) && !write |=>
      $stable(overflow_irq))
      else $error("irq moved while frozen");
endmodule

bind mt_modulo_timer mt_modulo_timer_asserts #(.NUM_TIMERS(NUM_TIMERS))
   mt_modulo_timer_asserts_inst
(
   .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
   .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
   .waitrequest(waitrequest), .ext_count_clock(ext_count_clock),
   .fixed_freq_clock_en(fixed_freq_clock_en), .wait_mode(wait_mode),
   .stop_mode(stop_mode), .debug_active(debug_active), .overflow_irq(overflow_irq)
);

// file: verification/mt_modulo_timer_tb_top.sv
`timescale 1ns/100ps

module mt_modulo_timer_tb_top;
   typedef struct packed {logic w; logic [5:0] a; logic [7:0] d; logic [7:0] e;} mt_row_type;
   logic        clk = 1'h0;
   logic        rst_n = 1'h0;
   logic [5:0]  address = 6'h00;
   logic        read = 1'h0;
   logic        write = 1'h0;
   logic [31:0] writedata = 32'h0;
   logic [3:0]  byteenable = 4'hf;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [1:0]  ext_count_clock = 2'h0;
   logic        fixed_freq_clock_en = 1'h0;
   logic        wait_mode = 1'h0;
   logic        stop_mode = 1'h0;
   logic        debug_active = 1'h0;
   logic [1:0]  overflow_irq;
   logic [7:0]  rd;
   int          bad_count = 0;
   int          check_count = 0;
   mt_row_type  rows [15] = '{'{1'h0,6'h00,8'h00,8'h10}, '{1'h0,6'h04,8'h00,8'h00},
      '{1'h0,6'h08,8'h00,8'h00}, '{1'h0,6'h0c,8'h00,8'h00}, '{1'h0,6'h10,8'h00,8'h10},
      '{1'h0,6'h14,8'h00,8'h00}, '{1'h1,6'h04,8'hff,8'h3f}, '{1'h1,6'h04,8'h00,8'h00},
      '{1'h1,6'h00,8'hff,8'h50}, '{1'h1,6'h00,8'h10,8'h10}, '{1'h1,6'h08,8'h55,8'h00},
      '{1'h1,6'h0c,8'h7f,8'h7f}, '{1'h1,6'h0c,8'h00,8'h00}, '{1'h1,6'h3c,8'haa,8'h00},
      '{1'h0,6'h3c,8'h00,8'h00}};

   always #2.5 clk = ~clk;

   mt_modulo_timer mt_modulo_timer_inst
   (
      .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .ext_count_clock(ext_count_clock),
      .fixed_freq_clock_en(fixed_freq_clock_en), .wait_mode(wait_mode),
      .stop_mode(stop_mode), .debug_active(debug_active), .overflow_irq(overflow_irq)
   );

   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      address <= a;
      writedata <= {24'h0, d};
      write <= w;
      read <= !w;
      do @(posedge clk); while (waitrequest !== 1'h0);
      rd = readdata[7:0];
      write <= 1'h0;
      read <= 1'h0;
   endtask

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic rc(input logic [5:0] a, input logic [7:0] e, input string n);
      bus(1'h0, a, 8'h00);
      chk(n, e, rd);
   endtask

   task automatic pulse(input int n);
      repeat (n)
      begin
         @(posedge clk);
         fixed_freq_clock_en <= 1'h1;
         @(posedge clk);
         fixed_freq_clock_en <= 1'h0;
      end
   endtask

   task automatic finish_test;
      $display("Checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      #100000;
      bad_count++;
      finish_test();
   end

   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      foreach (rows[i])
      begin
         if (rows[i].w)
            bus(1'h1, rows[i].a, rows[i].d);
         rc(rows[i].a, rows[i].e, "register");
      end
      // Wrap at terminal on the fixed source
      bus(1'h1, 6'h04, 8'h10);
      bus(1'h1, 6'h0c, 8'h03);
      bus(1'h1, 6'h00, 8'h00);
      pulse(3);
      rc(6'h08, 8'h03, "count");
      pulse(1);
      bus(1'h1, 6'h00, 8'h80);
      rc(6'h08, 8'h00, "wrap count");
      rc(6'h00, 8'h80, "flag set");
      bus(1'h1, 6'h00, 8'h00);
      rc(6'h00, 8'h00, "flag cleared");
      bus(1'h1, 6'h00, 8'h40);
      pulse(4);
      @(posedge clk);
      chk("irq", 8'h01, {7'h0, overflow_irq[0]});
      bus(1'h1, 6'h0c, 8'h03);
      rc(6'h00, 8'h40, "terminal write");
      // Power modes, frozen at a nonzero count
      pulse(1);
      stop_mode <= 1'h1;
      pulse(2);
      rc(6'h08, 8'h01, "stop");
      stop_mode <= 1'h0;
      debug_active <= 1'h1;
      pulse(2);
      rc(6'h08, 8'h01, "debug");
      debug_active <= 1'h0;
      wait_mode <= 1'h1;
      pulse(2);
      rc(6'h08, 8'h03, "wait");
      wait_mode <= 1'h0;
      bus(1'h1, 6'h00, 8'h10);
      pulse(2);
      rc(6'h08, 8'h03, "halt");
      bus(1'h1, 6'h00, 8'h20);
      rc(6'h08, 8'h00, "counter reset");
      // Prescale codes 0 to 9
      for (int p = 0; p < 10; p++)
      begin
         bus(1'h1, 6'h04, {4'h1, 4'(p)});
         bus(1'h1, 6'h0c, 8'h00);
         pulse(2 << (p > 8 ? 8 : p));
         rc(6'h08, 8'h02, "prescale");
      end
      // External pin, falling then rising
      for (int s = 2; s < 4; s++)
      begin
         bus(1'h1, 6'h04, {2'h0, 2'(s), 4'h0});
         bus(1'h1, 6'h0c, 8'h00);
         repeat (6)
         begin
            @(posedge clk);
            ext_count_clock[0] <= ~ext_count_clock[0];
            repeat (4) @(posedge clk);
         end
         repeat (6) @(posedge clk);
         rc(6'h08, 8'h03, "external");
      end
      // Cascade from timer two
      bus(1'h1, 6'h20, 8'h01);
      bus(1'h1, 6'h0c, 8'h00);
      bus(1'h1, 6'h14, 8'h10);
      bus(1'h1, 6'h1c, 8'h01);
      bus(1'h1, 6'h10, 8'h40);
      pulse(4);
      @(posedge clk);
      chk("irq two", 8'h01, {7'h0, overflow_irq[1]});
      rc(6'h08, 8'h02, "cascade");
      // Write with the low byte lane off is ignored
      byteenable <= 4'he;
      bus(1'h1, 6'h0c, 8'h55);
      byteenable <= 4'hf;
      rc(6'h0c, 8'h00, "byte lane");
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      rc(6'h00, 8'h10, "reset again");
      finish_test();
   end
endmodule
